// ### core/cirw_pkg.sv
// Shared constants, types and decoders for the indexed register window.
package cirw_pkg;

    // ==========================================================
    // Register locations
    localparam logic [7:0] SFR_PAGE_CAN = 8'h01;
    localparam logic [7:0] SFR_CTRL = 8'hF8;
    localparam logic [7:0] SFR_TEST = 8'hDB;
    localparam logic [7:0] SFR_STAT = 8'hC0;
    localparam logic [7:0] SFR_DATH = 8'hD9;
    localparam logic [7:0] SFR_DATL = 8'hD8;
    localparam logic [7:0] SFR_ADR = 8'hDA;

    // ==========================================================
    // Controller index space and fields
    localparam int IDX_W = 7;
    localparam logic [IDX_W-1:0] IDX_CTRL = 7'h00;
    localparam logic [IDX_W-1:0] IDX_STAT = 7'h01;
    localparam logic [IDX_W-1:0] IDX_TEST = 7'h05;
    localparam int CTRL_IRQ_BIT = 4;
    localparam logic [7:0] MSG_ONE_FIRST = 8'h08;
    localparam logic [7:0] MSG_ONE_LAST = 8'h12;
    localparam logic [7:0] MSG_TWO_FIRST = 8'h20;
    localparam logic [7:0] MSG_TWO_LAST = 8'h2A;
    localparam logic [1:0] BE_WORD = 2'h3;
    localparam logic [1:0] BE_LOW = 2'h1;

    // ==========================================================
    // Reset values
    localparam logic [7:0] DATH_RESET = 8'h00;
    localparam logic [7:0] PTR_RESET = 8'h00;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] page;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } cirw_sfr_req_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [IDX_W-1:0] index;
        logic [1:0] be;
        logic [15:0] wdata;
    } cirw_ctl_req_t;

    typedef enum logic [1:0] {
        CIRW_IDLE = 2'b01,
        CIRW_FETCH = 2'b10
    } cirw_state_t;

    // ==========================================================
    // Decoders
    function automatic logic in_autoinc(input logic [7:0] p);
        return (p >= MSG_ONE_FIRST && p <= MSG_ONE_LAST) ||
               (p >= MSG_TWO_FIRST && p <= MSG_TWO_LAST);
    endfunction

    function automatic logic sfr_hit(input cirw_sfr_req_t r,
                                     input logic [7:0] a);
        return (r.page == SFR_PAGE_CAN) && (r.addr == a);
    endfunction

    // The interrupt indicator is not a controller bit: it is substituted on
    // reads and forced low on writes of the control word's low byte.
    function automatic logic [7:0] ctrl_patch(input logic [7:0] b,
                                              input logic [IDX_W-1:0] idx,
                                              input logic irq);
        logic [7:0] r;
        r = b;
        if (idx == IDX_CTRL) begin
            r[CTRL_IRQ_BIT] = irq;
        end
        return r;
    endfunction

endpackage

// ### core/cirw_index_ptr.sv
// Index pointer with message-interface auto-increment.
module cirw_index_ptr
    import cirw_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [7:0] load_value,
    input wire logic step,
    output logic [7:0] ptr
);

    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;

    always_comb begin
        ptr_next = ptr_reg;
        if (load) begin
            ptr_next = load_value;
        end else if (step && in_autoinc(ptr_reg)) begin
            ptr_next = ptr_reg + 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ptr_reg <= PTR_RESET;
        end else begin
            ptr_reg <= ptr_next;
        end
    end

    assign ptr = ptr_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    step_in_range_a: assert property (
        step && !load && in_autoinc(ptr) |=> ptr == $past(ptr) + 8'h01)
        else $error("pointer did not advance inside an interface range");
    step_outside_a: assert property (
        step && !load && !in_autoinc(ptr) |=> $stable(ptr))
        else $error("pointer moved outside the interface ranges");

endmodule

// ### core/cirw_window.sv
// Byte-wide special-function window onto the 16-bit controller registers.
module cirw_window
    import cirw_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire cirw_sfr_req_t sfr,
    input wire logic [15:0] ctl_rdata,
    input wire logic ctl_irq_active,
    output logic [7:0] sfr_rdata,
    output logic sfr_rvalid,
    output cirw_ctl_req_t ctl_req,
    output logic irq_flag
);

    // ==========================================================
    // State
    cirw_state_t state_reg, state_next;
    cirw_ctl_req_t req_reg, req_next;
    logic [7:0] dath_reg, dath_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic hi_sel_reg, hi_sel_next;
    logic irq_reg, irq_next;
    logic ptr_load, ptr_step;
    // Only the low seven pointer bits index the controller; bit 7 is kept
    // so that software reads back exactly what it wrote.
    logic [7:0] ptr;
    logic [IDX_W-1:0] wr_idx;

    cirw_index_ptr u_ptr (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .load(ptr_load),
        .load_value(sfr.wdata),
        .step(ptr_step),
        .ptr(ptr)
    );

    // ==========================================================
    // Access sequencing
    // A controller read takes one extra cycle so that the returned word is
    // sampled from a registered request; the bus is refused meanwhile.
    always_comb begin
        state_next = state_reg;
        req_next = req_reg;
        req_next.wr = 1'b0;
        req_next.rd = 1'b0;
        dath_next = dath_reg;
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        hi_sel_next = hi_sel_reg;
        ptr_load = 1'b0;
        ptr_step = 1'b0;
        wr_idx = IDX_CTRL;
        irq_next = ctl_irq_active;
        unique case (state_reg)
            CIRW_IDLE: begin
                if (sfr.wr) begin
                    if (sfr_hit(sfr, SFR_ADR)) begin
                        ptr_load = 1'b1;
                    end else if (sfr_hit(sfr, SFR_DATH)) begin
                        dath_next = sfr.wdata;
                    end else if (sfr_hit(sfr, SFR_DATL)) begin
                        wr_idx = ptr[IDX_W-1:0];
                        req_next.wr = 1'b1;
                        req_next.index = wr_idx;
                        req_next.be = BE_WORD;
                        req_next.wdata = {dath_reg,
                            ctrl_patch(sfr.wdata, wr_idx, 1'b0)};
                        ptr_step = 1'b1;
                    end else if (sfr_hit(sfr, SFR_CTRL) ||
                                 sfr_hit(sfr, SFR_TEST) ||
                                 sfr_hit(sfr, SFR_STAT)) begin
                        wr_idx = sfr_hit(sfr, SFR_CTRL) ? IDX_CTRL :
                                 sfr_hit(sfr, SFR_TEST) ? IDX_TEST :
                                 IDX_STAT;
                        req_next.wr = 1'b1;
                        req_next.index = wr_idx;
                        req_next.be = BE_LOW;
                        req_next.wdata = {8'h00,
                            ctrl_patch(sfr.wdata, wr_idx, 1'b0)};
                    end
                end else if (sfr.rd) begin
                    if (sfr_hit(sfr, SFR_ADR)) begin
                        rdata_next = ptr;
                        rvalid_next = 1'b1;
                    end else if (sfr_hit(sfr, SFR_DATH) ||
                                 sfr_hit(sfr, SFR_DATL)) begin
                        req_next.rd = 1'b1;
                        req_next.index = ptr[IDX_W-1:0];
                        hi_sel_next = sfr_hit(sfr, SFR_DATH);
                        state_next = CIRW_FETCH;
                    end else if (sfr_hit(sfr, SFR_CTRL) ||
                                 sfr_hit(sfr, SFR_TEST) ||
                                 sfr_hit(sfr, SFR_STAT)) begin
                        req_next.rd = 1'b1;
                        req_next.index = sfr_hit(sfr, SFR_CTRL) ? IDX_CTRL :
                                         sfr_hit(sfr, SFR_TEST) ? IDX_TEST :
                                         IDX_STAT;
                        hi_sel_next = 1'b0;
                        state_next = CIRW_FETCH;
                    end
                end
            end
            // Strobes seen here are dropped, so software must leave one idle
            // cycle after any controller read.
            CIRW_FETCH: begin
                rdata_next = hi_sel_reg ? ctl_rdata[15:8] :
                    ctrl_patch(ctl_rdata[7:0], req_reg.index,
                               irq_reg);
                rvalid_next = 1'b1;
                state_next = CIRW_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= CIRW_IDLE;
            req_reg <= '0;
            dath_reg <= DATH_RESET;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
            hi_sel_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            req_reg <= req_next;
            dath_reg <= dath_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            hi_sel_reg <= hi_sel_next;
            irq_reg <= irq_next;
        end
    end

    assign sfr_rdata = rdata_reg;
    assign sfr_rvalid = rvalid_reg;
    assign ctl_req = req_reg;
    assign irq_flag = irq_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence ctrl_read_req;
        state_reg == CIRW_IDLE && !sfr.wr && sfr.rd && sfr_hit(sfr, SFR_CTRL);
    endsequence
    sequence ctrl_read_fetch;
        ctl_req.rd && ctl_req.index == IDX_CTRL;
    endsequence

    datl_route_a: assert property (
        state_reg == CIRW_IDLE && sfr.wr && sfr_hit(sfr, SFR_DATL)
        |=> ctl_req.wr && ctl_req.index == $past(ptr[IDX_W-1:0]))
        else $error("low byte write not routed to the pointed register");
    word_pair_a: assert property (
        state_reg == CIRW_IDLE && sfr.wr && sfr_hit(sfr, SFR_DATL)
        |=> ctl_req.be == BE_WORD && ctl_req.wdata[15:8] == $past(dath_reg))
        else $error("word write did not carry the stored high byte");
    ctrl_wr_mask_a: assert property (
        ctl_req.wr && ctl_req.index == IDX_CTRL |-> !ctl_req.wdata[CTRL_IRQ_BIT])
        else $error("interrupt indicator was written to the controller");
    ctrl_irq_read_a: assert property (
        ctrl_read_req |=> ctrl_read_fetch ##1
        (sfr_rvalid && sfr_rdata[CTRL_IRQ_BIT] == $past(irq_reg)))
        else $error("control read did not show the interrupt indicator");
    irq_drop_a: assert property (
        $fell(irq_flag) |-> !$past(ctl_irq_active))
        else $error("indicator dropped while the controller still interrupts");
    datl_read_a: assert property (
        state_reg == CIRW_IDLE && !sfr.wr && sfr.rd && sfr_hit(sfr, SFR_DATL)
        |=> ctl_req.rd && ctl_req.index == $past(ptr[IDX_W-1:0])
        ##1 sfr_rvalid)
        else $error("indexed read not fetched from the pointed register");
    test_direct_a: assert property (
        state_reg == CIRW_IDLE && sfr.wr && sfr_hit(sfr, SFR_TEST)
        |=> ctl_req.wr && ctl_req.index == IDX_TEST && ctl_req.be == BE_LOW)
        else $error("direct test write did not reach the test register");
    page_decode_a: assert property (
        sfr.page != SFR_PAGE_CAN |=> !ctl_req.wr && !ctl_req.rd)
        else $error("direct register decoded on a foreign page");
    reset_clear_a: assert property (disable iff (1'b0)
        !rst_n |=> dath_reg == DATH_RESET && ptr == PTR_RESET)
        else $error("reset did not clear high byte and pointer");

    sequence dath_read_req;
        state_reg == CIRW_IDLE && !sfr.wr && sfr.rd &&
        sfr_hit(sfr, SFR_DATH);
    endsequence

    dath_read_a: assert property (
        dath_read_req |=> !sfr_rvalid ##1
        (sfr_rvalid && sfr_rdata == $past(ctl_rdata[15:8])))
        else $error("high byte read did not return the controller bits");
    dath_store_a: assert property (
        state_reg == CIRW_IDLE && sfr.wr && sfr_hit(sfr, SFR_DATH)
        |=> !ctl_req.wr && dath_reg == $past(sfr.wdata))
        else $error("high byte write was not held for the word write");
    ctrl_direct_a: assert property (
        state_reg == CIRW_IDLE && sfr.wr && sfr_hit(sfr, SFR_CTRL)
        |=> ctl_req.wr && ctl_req.index == IDX_CTRL && ctl_req.be == BE_LOW)
        else $error("direct control write did not reach the control word");
    stat_direct_a: assert property (
        state_reg == CIRW_IDLE && sfr.wr && sfr_hit(sfr, SFR_STAT)
        |=> ctl_req.wr && ctl_req.index == IDX_STAT && ctl_req.be == BE_LOW)
        else $error("direct status write did not reach the status word");
    ptr_answer_a: assert property (
        state_reg == CIRW_IDLE && !sfr.wr && sfr.rd && sfr_hit(sfr, SFR_ADR)
        |=> sfr_rvalid && sfr_rdata == $past(ptr))
        else $error("pointer read did not return the pointer value");
    fetch_refuse_a: assert property (
        state_reg == CIRW_FETCH |=> !ctl_req.wr && !ctl_req.rd)
        else $error("a strobe was taken during a controller fetch");
    irq_rise_a: assert property (
        ctl_irq_active |=> irq_flag)
        else $error("indicator did not follow a pending interrupt");

endmodule

// ### testbench/cirw_ctl_model.sv
// Behavioural controller register file behind the indexed window.
module cirw_ctl_model
    import cirw_pkg::*;
(
    input wire logic ref_clk,
    input wire cirw_ctl_req_t ctl_req,
    output logic [15:0] ctl_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Word store
    logic [15:0] mem [128] = '{default: 16'h0000};

    // A word lands on the edge that ends the write pulse.
    always @(posedge ref_clk) begin
        if (ctl_req.wr) begin
            if (ctl_req.be[1]) begin
                mem[ctl_req.index][15:8] <= ctl_req.wdata[15:8];
            end
            if (ctl_req.be[0]) begin
                mem[ctl_req.index][7:0] <= ctl_req.wdata[7:0];
            end
        end
    end

    // Outside a read cycle the bus shows the inverse, so a late sample fails.
    assign ctl_rdata = ctl_req.rd ? mem[ctl_req.index] : ~mem[ctl_req.index];
endmodule

// ### testbench/can_indexed_register_window_test.sv
// Self-checking bench for the indexed register window.
module can_indexed_register_window_test
    import cirw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ctl_irq_active = 1'b0;
    cirw_sfr_req_t sfr = '0;
    logic [15:0] ctl_rdata;
    logic [7:0] sfr_rdata;
    logic sfr_rvalid;
    cirw_ctl_req_t ctl_req;
    logic irq_flag;
    int num_errors = 0;
    int num_checks = 0;
    logic [7:0] ptrs [8] = '{8'h07, 8'h08, 8'h12, 8'h13,
                             8'h1F, 8'h20, 8'h2A, 8'h2B};
    logic [7:0] nexts [8] = '{8'h07, 8'h09, 8'h13, 8'h13,
                              8'h1F, 8'h21, 8'h2B, 8'h2B};

    `define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
        num_errors++; \
        $display("wrong value at %0t: %h not %h", $time, got, exp); end end

    cirw_window DUT (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sfr(sfr),
        .ctl_rdata(ctl_rdata),
        .ctl_irq_active(ctl_irq_active),
        .sfr_rdata(sfr_rdata),
        .sfr_rvalid(sfr_rvalid),
        .ctl_req(ctl_req),
        .irq_flag(irq_flag)
    );

    cirw_ctl_model ctl_model (
        .ref_clk(ref_clk),
        .ctl_req(ctl_req),
        .ctl_rdata(ctl_rdata)
    );

    // ==========================================================
    // Bus tasks
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d,
                          input logic [7:0] pg = SFR_PAGE_CAN);
        @(posedge ref_clk);
        sfr <= '{addr: a, page: pg, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge ref_clk);
        sfr.wr <= 1'b0;
    endtask

    // A missing answer yields unknowns, so the comparison fails.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        int n;
        logic [7:0] d;
        n = 0;
        @(posedge ref_clk);
        sfr <= '{addr: a, page: SFR_PAGE_CAN, wr: 1'b0, rd: 1'b1,
                 wdata: 8'h00};
        @(posedge ref_clk);
        sfr.rd <= 1'b0;
        #1;
        while (sfr_rvalid !== 1'b1 && n < 4) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        d = (n == 4) ? 8'hXX : sfr_rdata;
        `CHK(d, e)
    endtask

    task automatic mem_chk(input int i, input logic [15:0] e);
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK(ctl_model.mem[i], e)
    endtask

    task automatic conclude;
        if (num_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Clock, watchdog and tests
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    initial begin
        #20000;
        num_errors++;
        conclude();
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_chk(SFR_ADR, 8'h00);
        sfr_wr(SFR_DATL, 8'h5A);
        mem_chk(0, 16'h004A);
        rd_chk(SFR_ADR, 8'h00);
        sfr_wr(SFR_ADR, 8'h03);
        sfr_wr(SFR_DATH, 8'h23);
        sfr_wr(SFR_DATL, 8'h04);
        mem_chk(3, 16'h2304);
        rd_chk(SFR_DATL, 8'h04);
        rd_chk(SFR_DATH, 8'h23);
        rd_chk(SFR_ADR, 8'h03);
        foreach (ptrs[i]) begin
            sfr_wr(SFR_ADR, ptrs[i]);
            sfr_wr(SFR_DATL, 8'h00);
            rd_chk(SFR_ADR, nexts[i]);
        end
        sfr_wr(SFR_CTRL, 8'h1F);
        mem_chk(0, 16'h000F);
        sfr_wr(SFR_ADR, 8'h00);
        rd_chk(SFR_DATL, 8'h0F);
        @(posedge ref_clk);
        ctl_irq_active <= 1'b1;
        rd_chk(SFR_CTRL, 8'h1F);
        rd_chk(SFR_DATL, 8'h1F);
        `CHK(irq_flag, 1'b1)
        @(posedge ref_clk);
        ctl_irq_active <= 1'b0;
        rd_chk(SFR_CTRL, 8'h0F);
        `CHK(irq_flag, 1'b0)
        sfr_wr(SFR_TEST, 8'h81);
        sfr_wr(SFR_ADR, 8'h05);
        rd_chk(SFR_DATL, 8'h81);
        sfr_wr(SFR_DATL, 8'h33);
        rd_chk(SFR_TEST, 8'h33);
        sfr_wr(SFR_STAT, 8'h07);
        rd_chk(SFR_STAT, 8'h07);
        sfr_wr(SFR_ADR, 8'h01);
        rd_chk(SFR_DATL, 8'h07);
        sfr_wr(SFR_ADR, 8'h7F);
        sfr_wr(SFR_DATH, 8'hBE);
        sfr_wr(SFR_DATL, 8'hEF);
        mem_chk(127, 16'hBEEF);
        sfr_wr(SFR_STAT, 8'h55, 8'h00);
        mem_chk(1, 16'h0007);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_chk(SFR_ADR, 8'h00);
        sfr_wr(SFR_ADR, 8'h06);
        sfr_wr(SFR_DATL, 8'h11);
        mem_chk(6, 16'h0011);
        conclude();
    end
endmodule
